// >>> dcf_map.svh
// Register offsets, field positions, reset values and threshold width for the FIFO block.
`ifndef DCF_MAP_SVH
`define DCF_MAP_SVH
`define DCF_CFG_OFS 8'h00
`define DCF_NE_THR_OFS 8'h04
`define DCF_NF_THR_OFS 8'h08
`define DCF_STATUS_OFS 8'h0C
`define DCF_PTRS_OFS 8'h10
`define DCF_CFG_SINGLE_BIT 0
`define DCF_CFG_AHEAD_BIT 1
`define DCF_CFG_PIPE_BIT 2
`define DCF_CFG_RST 3'h0
`define DCF_NE_THR_RST 13'h0010
`define DCF_NF_THR_RST 13'h0010
`define DCF_THR_W 13
`define DCF_ST_EMPTY_BIT 0
`define DCF_ST_NEMPTY_BIT 1
`define DCF_ST_FULL_BIT 2
`define DCF_ST_NFULL_BIT 3
`define DCF_ST_UNDER_BIT 4
`define DCF_ST_OVER_BIT 5
`define DCF_PTRS_WR_LSB 16
`endif

// >>> dcf_pkg.sv
// Types shared by the FIFO block.
package dcf_pkg;
  typedef enum {
    DCF_RM_STANDARD,
    DCF_RM_AHEAD,
    DCF_RM_PIPED
  } dcf_rdmode_t;
  typedef logic [1:0] dcf_htrans_t;
endpackage

// >>> dcf_fifo.sv
// Dual-clock FIFO with status flags, pointer counts and an AHB-Lite configuration port.
`timescale 1ns/1ps
`include "dcf_map.svh"
// Notes on behaviour
// - Write stores data and parity on write clock edge when enabled and not full.
// - Read moves next stored word to output register when enabled and not empty.
// - FIFO reset clears pointers and flags, not memory nor output register.
// - During reset empty and near-empty read 1, full and near-full 0.
// - Standard mode: empty falls on read clock, first word needs a read.
// - Show-ahead mode: first word appears without read; later reads need enable.
// - Single-clock mode flags move with no added latency.
// - Dual-clock empty asserts at once, clears after three or four read clocks.
// - Dual-clock full asserts at once, clears three or four write clocks after reads.
// - Near flags assert after one cycle and clear after three.
// - Empty rises on last read; read pointer frozen while nothing stored.
// - Full rises when no space; write pointer frozen, writes rejected.
// - Read while empty holds pointer and raises underflow until enable or empty drops.
// - Write while full holds pointer and raises overflow until enable or full drops.
// - Near-empty sets at count at or below threshold, clears above threshold plus one.
// - Near-full sets at free space at or below threshold, clears above threshold plus one.
// - Pointer count outputs wrap to zero after their maximum.
// - Read-side outputs follow read clock (write clock in single-clock mode); write-side outputs follow write clock.
// - Empty release crosses into read domain through synchronising flops.
// - Show-ahead only available in dual-clock configuration.
// - Single-clock piped output delivers data one cycle later.
module dcf_fifo #(
  parameter int DATA_W = 32,
  parameter int PAR_W = 4,
  parameter int ADDR_W = 9
) (
  // System clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // AHB-Lite register port.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire dcf_pkg::dcf_htrans_t htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // FIFO pins, sampled from outside the clock domain.
  input wire logic write_clock,
  input wire logic read_clock,
  input wire logic fifo_reset,
  input wire logic write_enable,
  input wire logic read_enable,
  input wire logic [DATA_W-1:0] write_data_in,
  input wire logic [PAR_W-1:0] write_parity_in,
  input wire logic output_reg_sync_reset,
  input wire logic output_reg_clock_enable,
  // Read-side results.
  output logic [DATA_W-1:0] read_data_out,
  output logic [PAR_W-1:0] read_parity_out,
  output logic empty,
  output logic near_empty_warning,
  output logic underflow_error,
  output logic [ADDR_W-1:0] read_pointer_value,
  // Write-side results.
  output logic full,
  output logic near_full_warning,
  output logic overflow_error,
  output logic [ADDR_W-1:0] write_pointer_value
);
  import dcf_pkg::*;

  localparam int PTR_W = ADDR_W + 1;
  localparam int WORD_W = DATA_W + PAR_W;
  localparam int DEPTH = 1 << ADDR_W;
  localparam logic [PTR_W-1:0] DEPTH_P = PTR_W'(DEPTH);
  localparam logic [DATA_W-1:0] SRVAL_D = '0;
  localparam logic [PAR_W-1:0] SRVAL_P = '0;

  function automatic logic [PTR_W-1:0] bin2gray(input logic [PTR_W-1:0] b);
    bin2gray = b ^ (b >> 1);
  endfunction

  function automatic logic [PTR_W-1:0] gray2bin(input logic [PTR_W-1:0] g);
    logic [PTR_W-1:0] b;
    b = '0;
    for (int i = PTR_W - 1; i >= 0; i--) begin
      b[i] = (i == PTR_W - 1) ? g[i] : (b[i+1] ^ g[i]);
    end
    gray2bin = b;
  endfunction

  // Pin synchronisers: stage one feeds stage two only.
  logic [3:0] ctl_s1_r, ctl_s2_r;
  logic wclk_s3_r, rclk_s3_r;
  logic [WORD_W-1:0] wword_s1_r, wword_s2_r;
  logic [1:0] ce_sr_s1_r, ce_sr_s2_r;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctl_s1_r <= 4'h0;
      ctl_s2_r <= 4'h0;
      wclk_s3_r <= 1'b0;
      rclk_s3_r <= 1'b0;
      ce_sr_s1_r <= 2'h0;
      ce_sr_s2_r <= 2'h0;
    end else begin
      ctl_s1_r <= {write_clock, read_clock, write_enable, read_enable};
      ctl_s2_r <= ctl_s1_r;
      wclk_s3_r <= ctl_s2_r[3];
      rclk_s3_r <= ctl_s2_r[2];
      ce_sr_s1_r <= {output_reg_clock_enable, output_reg_sync_reset};
      ce_sr_s2_r <= ce_sr_s1_r;
    end
  end

  // Data path staging needs no reset; it is aligned with the enables above.
  always_ff @(posedge clk) begin
    wword_s1_r <= {write_parity_in, write_data_in};
    wword_s2_r <= wword_s1_r;
  end

  // FIFO reset: asserts at once, releases after two clocks to avoid a ragged release.
  logic frst_s1_r, frst_r;
  always_ff @(posedge clk or negedge reset_n or posedge fifo_reset) begin
    if (!reset_n || fifo_reset) begin
      frst_s1_r <= 1'b1;
      frst_r <= 1'b1;
    end else begin
      frst_s1_r <= 1'b0;
      frst_r <= frst_s1_r;
    end
  end

  // Configuration registers written over the bus.
  logic [2:0] cfg_r;
  logic [`DCF_THR_W-1:0] ne_thr_r, nf_thr_r;
  logic single_clock_select, show_ahead_mode, pipe_sel;
  assign single_clock_select = cfg_r[`DCF_CFG_SINGLE_BIT];
  assign show_ahead_mode = cfg_r[`DCF_CFG_AHEAD_BIT] & ~single_clock_select;
  assign pipe_sel = cfg_r[`DCF_CFG_PIPE_BIT] & single_clock_select;
  dcf_rdmode_t rd_mode;
  always_comb begin
    if (show_ahead_mode) begin
      rd_mode = DCF_RM_AHEAD;
    end else if (pipe_sel) begin
      rd_mode = DCF_RM_PIPED;
    end else begin
      rd_mode = DCF_RM_STANDARD;
    end
  end

  // Edge ticks standing for the two clocks; single-clock mode ties reads to the write clock.
  logic wr_tick, rd_tick, we_s, re_s;
  assign wr_tick = ctl_s2_r[3] & ~wclk_s3_r;
  assign rd_tick = single_clock_select ? wr_tick : (ctl_s2_r[2] & ~rclk_s3_r);
  assign we_s = ctl_s2_r[1];
  assign re_s = ctl_s2_r[0];

  logic [WORD_W-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wptr_r, rptr_r, wgray_r, rgray_r;
  logic [PTR_W-1:0] rs_wg1_r, rs_wg2_r, ws_rg1_r, ws_rg2_r;
  logic out_valid_r, empty_r, full_r;
  logic do_write, do_read;
  logic [PTR_W-1:0] wptr_nxt, rptr_nxt, wseen, rseen, rd_cnt, rd_cnt_nxt, wr_cnt_nxt;
  logic out_valid_nxt, mem_empty;

  // Pointer arithmetic on both sides; single-clock mode sees the other pointer directly.
  assign do_write = wr_tick & we_s & ~full_r & ~frst_r;
  assign wptr_nxt = wptr_r + PTR_W'(do_write);
  assign wseen = single_clock_select ? wptr_nxt : gray2bin(rs_wg2_r);
  assign rd_cnt = wseen - rptr_r;
  assign mem_empty = (rd_cnt == '0);
  always_comb begin
    case (rd_mode)
      DCF_RM_AHEAD: do_read = rd_tick & ~mem_empty & (~out_valid_r | re_s);
      DCF_RM_STANDARD, DCF_RM_PIPED: do_read = rd_tick & re_s & ~empty_r & ~mem_empty;
      default: do_read = 1'b0;
    endcase
  end
  assign rptr_nxt = rptr_r + PTR_W'(do_read);
  assign rd_cnt_nxt = wseen - rptr_nxt;
  assign out_valid_nxt = do_read | (out_valid_r & ~(rd_tick & re_s));
  assign rseen = single_clock_select ? rptr_nxt : gray2bin(ws_rg2_r);
  assign wr_cnt_nxt = wptr_nxt - rseen;

  // Memory write; contents survive any reset.
  always_ff @(posedge clk) begin
    if (do_write) begin
      mem[wptr_r[ADDR_W-1:0]] <= wword_s2_r;
    end
  end

  // Write pointer, its Gray copy and the read pointer synchronised on write ticks.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wptr_r <= '0;
      wgray_r <= '0;
      ws_rg1_r <= '0;
      ws_rg2_r <= '0;
    end else if (frst_r) begin
      wptr_r <= '0;
      wgray_r <= '0;
      ws_rg1_r <= '0;
      ws_rg2_r <= '0;
    end else if (wr_tick) begin
      wptr_r <= wptr_nxt;
      wgray_r <= bin2gray(wptr_nxt);
      ws_rg1_r <= rgray_r;
      ws_rg2_r <= ws_rg1_r;
    end
  end

  // Read pointer, its Gray copy and the write pointer synchronised on read ticks.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rptr_r <= '0;
      rgray_r <= '0;
      rs_wg1_r <= '0;
      rs_wg2_r <= '0;
      out_valid_r <= 1'b0;
    end else if (frst_r) begin
      rptr_r <= '0;
      rgray_r <= '0;
      rs_wg1_r <= '0;
      rs_wg2_r <= '0;
      out_valid_r <= 1'b0;
    end else if (rd_tick) begin
      rptr_r <= rptr_nxt;
      rgray_r <= bin2gray(rptr_nxt);
      rs_wg1_r <= wgray_r;
      rs_wg2_r <= rs_wg1_r;
      out_valid_r <= out_valid_nxt;
    end
  end

  // Read-side flags. Show-ahead empty waits one more tick so the word is on the output first.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      empty_r <= 1'b1;
      near_empty_warning <= 1'b1;
      underflow_error <= 1'b0;
    end else if (frst_r) begin
      empty_r <= 1'b1;
      near_empty_warning <= 1'b1;
      underflow_error <= 1'b0;
    end else if (rd_tick) begin
      underflow_error <= re_s & empty_r;
      if (show_ahead_mode) begin
        empty_r <= ~(out_valid_r & out_valid_nxt);
      end else begin
        empty_r <= (rd_cnt_nxt == '0);
      end
      if (rd_cnt <= PTR_W'(ne_thr_r)) begin
        near_empty_warning <= 1'b1;
      end else if (rd_cnt > PTR_W'(ne_thr_r) + PTR_W'(1)) begin
        near_empty_warning <= 1'b0;
      end
    end
  end
  assign empty = empty_r;

  // Write-side flags.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      full_r <= 1'b0;
      near_full_warning <= 1'b0;
      overflow_error <= 1'b0;
    end else if (frst_r) begin
      full_r <= 1'b0;
      near_full_warning <= 1'b0;
      overflow_error <= 1'b0;
    end else if (wr_tick) begin
      overflow_error <= we_s & full_r;
      full_r <= (wr_cnt_nxt == DEPTH_P);
      if ((DEPTH_P - (wptr_r - rseen)) <= PTR_W'(nf_thr_r)) begin
        near_full_warning <= 1'b1;
      end else if ((DEPTH_P - (wptr_r - rseen)) > PTR_W'(nf_thr_r) + PTR_W'(1)) begin
        near_full_warning <= 1'b0;
      end
    end
  end
  assign full = full_r;

  // Output path. The piped form trades a cycle of latency for an extra register stage.
  logic [WORD_W-1:0] pipe_r, out_r;
  always_ff @(posedge clk) begin
    if (do_read) begin
      pipe_r <= mem[rptr_r[ADDR_W-1:0]];
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      out_r <= {SRVAL_P, SRVAL_D};
    end else if (rd_tick) begin
      if (ce_sr_s2_r[0]) begin
        out_r <= {SRVAL_P, SRVAL_D};
      end else if (rd_mode == DCF_RM_PIPED) begin
        if (ce_sr_s2_r[1]) begin
          out_r <= pipe_r;
        end
      end else if (do_read) begin
        out_r <= mem[rptr_r[ADDR_W-1:0]];
      end
    end
  end
  assign read_data_out = out_r[DATA_W-1:0];
  assign read_parity_out = out_r[WORD_W-1:DATA_W];
  assign read_pointer_value = rptr_r[ADDR_W-1:0];
  assign write_pointer_value = wptr_r[ADDR_W-1:0];

  // AHB-Lite slave: zero wait states, always OKAY, read data fetched in the address phase.
  logic a_wr_r;
  logic [7:0] a_ofs_r;
  logic take;
  assign take = hsel & hready & htrans[1];
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      a_wr_r <= 1'b0;
      a_ofs_r <= 8'h00;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hready) begin
        a_wr_r <= take & hwrite & (hsize == 3'h2);
        a_ofs_r <= haddr[7:0];
      end
    end
  end

  // Register writes land in the data phase; changes are meant to be made while the FIFO is reset.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_r <= `DCF_CFG_RST;
      ne_thr_r <= `DCF_NE_THR_RST;
      nf_thr_r <= `DCF_NF_THR_RST;
    end else if (a_wr_r) begin
      case (a_ofs_r)
        `DCF_CFG_OFS: cfg_r <= hwdata[2:0];
        `DCF_NE_THR_OFS: ne_thr_r <= hwdata[`DCF_THR_W-1:0];
        `DCF_NF_THR_OFS: nf_thr_r <= hwdata[`DCF_THR_W-1:0];
        default: cfg_r <= cfg_r;
      endcase
    end
  end

  // Read mux; unmapped offsets read as zero.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hrdata <= 32'h0;
    end else if (take && !hwrite) begin
      case (haddr[7:0])
        `DCF_CFG_OFS: hrdata <= {29'h0, cfg_r};
        `DCF_NE_THR_OFS: hrdata <= {19'h0, ne_thr_r};
        `DCF_NF_THR_OFS: hrdata <= {19'h0, nf_thr_r};
        `DCF_STATUS_OFS: hrdata <= {26'h0, overflow_error, underflow_error, near_full_warning,
                                    full_r, near_empty_warning, empty_r};
        `DCF_PTRS_OFS: hrdata <= {(16 - ADDR_W)'(0), wptr_r[ADDR_W-1:0],
                                  (16 - ADDR_W)'(0), rptr_r[ADDR_W-1:0]};
        default: hrdata <= 32'h0;
      endcase
    end
  end
endmodule

// >>> dcf_fifo_assertions.sv
// Concurrent checks on the FIFO block's flag and pointer ports.
`timescale 1ns/1ps
module dcf_fifo_assertions #(
  parameter int ADDR_W = 9
) (
  // Clock and resets.
  input wire logic clk,
  input wire logic reset_n,
  input wire logic fifo_reset,
  // Flags and pointers.
  input wire logic empty,
  input wire logic near_empty_warning,
  input wire logic full,
  input wire logic near_full_warning,
  input wire logic underflow_error,
  input wire logic overflow_error,
  input wire logic [ADDR_W-1:0] read_pointer_value,
  input wire logic [ADDR_W-1:0] write_pointer_value
);
  // Every check lives in the one system clock domain.
  default clocking dc @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_reset_flags: assert property (fifo_reset [*3] |-> empty && near_empty_warning && !full && !near_full_warning)
    else $error("flags wrong while the FIFO is held in reset");
  // A pointer only ever steps by one, wraps, or is cleared.
  chk_rptr_step: assert property ($changed(read_pointer_value) |->
    read_pointer_value == ADDR_W'($past(read_pointer_value) + 1) || read_pointer_value == '0)
    else $error("read pointer jumped");
  chk_wptr_step: assert property ($changed(write_pointer_value) |->
    write_pointer_value == ADDR_W'($past(write_pointer_value) + 1) || write_pointer_value == '0)
    else $error("write pointer jumped");
  chk_full_frozen: assert property (full |=> $stable(write_pointer_value) || fifo_reset)
    else $error("write pointer moved while full");
  chk_under_rise: assert property ($rose(underflow_error) |-> $stable(read_pointer_value) && empty)
    else $error("underflow without empty or with a pointer step");
  chk_over_rise: assert property ($rose(overflow_error) |-> $stable(write_pointer_value) && full)
    else $error("overflow without full or with a pointer step");
  chk_empty_full: assert property (!(empty && full))
    else $error("empty and full together");
  // With a nonzero threshold the warning is always up by the tick on which the last slot fills.
  chk_full_near: assert property (full |-> near_full_warning)
    else $error("full without near full");
endmodule

// >>> dcf_partner.sv
// Writer and reader user logic driving the FIFO pins from the system clock.
`timescale 1ns/1ps
module dcf_partner (
  // System clock and mode.
  input wire logic clk,
  input wire logic same_clock,
  // Requests from the bench.
  input wire logic wr_on,
  input wire logic rd_on,
  input wire logic [35:0] wr_word,
  // FIFO pins.
  output logic write_clock,
  output logic read_clock,
  output logic write_enable,
  output logic read_enable,
  output logic [31:0] write_data_in,
  output logic [3:0] write_parity_in,
  // One-cycle marks just after each clock rise.
  output logic wr_rise,
  output logic rd_rise
);
  logic [2:0] wcnt = 3'h0;
  logic [3:0] rcnt = 4'h0;
  // Free-running clocks; periods of 8 and 10 cycles make the edges drift apart.
  always @(posedge clk) begin
    wcnt <= wcnt + 3'h1;
    rcnt <= (rcnt == 4'h9) ? 4'h0 : rcnt + 4'h1;
  end
  assign write_clock = wcnt[2];
  assign read_clock = same_clock ? wcnt[2] : (rcnt >= 4'h5);
  assign wr_rise = (wcnt == 3'h4);
  assign rd_rise = same_clock ? wr_rise : (rcnt == 4'h5);
  // Pins change only as a clock falls, so they are steady around every rise.
  initial begin
    write_enable = 1'b0;
    read_enable = 1'b0;
    {write_parity_in, write_data_in} = 36'h0;
  end
  always @(posedge clk) begin
    if (wcnt == 3'h7) begin
      write_enable <= wr_on;
      {write_parity_in, write_data_in} <= wr_on ? wr_word : ~{write_parity_in, write_data_in};
    end
    if (same_clock ? (wcnt == 3'h7) : (rcnt == 4'h9)) begin
      read_enable <= rd_on;
    end
  end
endmodule

// >>> tb_dcf_fifo.sv
// Self-checking bench for the dual-clock FIFO block.
`timescale 1ns/1ps
`include "dcf_map.svh"
module tb_dcf_fifo;
  import dcf_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic fifo_reset = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  dcf_htrans_t htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic wr_on = 1'b0, rd_on = 1'b0, same_clock = 1'b0, oreg_rst = 1'b0;
  logic [35:0] wr_word = 36'h0;
  logic [35:0] last;
  logic [31:0] hrdata, rv, write_data_in, read_data_out;
  logic hreadyout, hresp, write_clock, read_clock, write_enable, read_enable, wr_rise, rd_rise;
  logic empty, near_empty_warning, underflow_error, full, near_full_warning, overflow_error;
  logic [3:0] write_parity_in, read_parity_out;
  logic [8:0] read_pointer_value, write_pointer_value;
  logic [35:0] q[$];
  int n_fail = 0;
  int n_checks = 0;
  always #20 clk = ~clk;
  dcf_fifo u_dcf_fifo (.clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .write_clock, .read_clock, .fifo_reset, .write_enable,
    .read_enable, .write_data_in, .write_parity_in, .output_reg_sync_reset(oreg_rst),
    .output_reg_clock_enable(1'b1), .read_data_out, .read_parity_out, .empty, .near_empty_warning,
    .underflow_error, .read_pointer_value, .full, .near_full_warning, .overflow_error, .write_pointer_value);
  dcf_partner u_dcf_partner (.clk, .same_clock, .wr_on, .rd_on, .wr_word, .write_clock, .read_clock,
    .write_enable, .read_enable, .write_data_in, .write_parity_in, .wr_rise, .rd_rise);
  // Model queue: words offered while there is room are expected back in order.
  always @(posedge clk) begin
    if (wr_rise) begin
      wr_word <= {4'($urandom), 32'($urandom)};
      if (write_enable && q.size() < 512) begin
        q.push_back({write_parity_in, write_data_in});
      end
    end
  end
  task automatic check(input string name, input logic [35:0] seen, input logic [35:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test();
    if (n_fail == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // One single AHB transfer; the read word is left in rv.
  task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    ahb({24'h0, a}, 1'b0, 32'h0);
    check("register", {4'h0, rv}, {4'h0, e});
  endtask
  // Holds the enable across n rises of its clock, then lets the last tick land.
  task automatic burst(input logic rd, input int n);
    @(posedge clk iff (rd ? rd_rise : wr_rise));
    {rd_on, wr_on} <= rd ? 2'b10 : 2'b01;
    repeat (n) @(posedge clk iff (rd ? rd_rise : wr_rise));
    {rd_on, wr_on} <= 2'b00;
    repeat (3) @(posedge clk);
  endtask
  task automatic rd_chk(input string name);
    burst(1'b1, 1);
    check(name, {read_parity_out, read_data_out}, q.pop_front());
  endtask
  // Enables idle well before and during the FIFO reset; configuration only changes inside it.
  task automatic fifo_rst(input logic [31:0] cfg);
    repeat (40) @(posedge clk);
    fifo_reset <= 1'b1;
    ahb({24'h0, `DCF_CFG_OFS}, 1'b1, cfg);
    same_clock <= cfg[`DCF_CFG_SINGLE_BIT];
    repeat (40) @(posedge clk);
    fifo_reset <= 1'b0;
    repeat (40) @(posedge clk);
    q.delete();
  endtask
  initial begin
    void'($urandom(32'h0AE86F3F));
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    repeat (40) @(posedge clk);
    check("reset flags", {empty, near_empty_warning, full, near_full_warning}, 4'hC);
    rd_reg(`DCF_CFG_OFS, 32'(`DCF_CFG_RST));
    rd_reg(`DCF_NE_THR_OFS, 32'(`DCF_NE_THR_RST));
    rd_reg(`DCF_NF_THR_OFS, 32'(`DCF_NF_THR_RST));
    rd_reg(`DCF_STATUS_OFS, (32'h1 << `DCF_ST_EMPTY_BIT) | (32'h1 << `DCF_ST_NEMPTY_BIT));
    rd_reg(8'h20, 32'h0);
    fifo_rst(32'h0);
    burst(1'b0, 3);
    check("empty lag", empty, 1'b1);
    repeat (60) @(posedge clk);
    check("empty", empty, 1'b0);
    check("write count", write_pointer_value, 9'h3);
    check("no fall through", {read_parity_out, read_data_out}, 36'h0);
    repeat (3) rd_chk("standard data");
    check("empty after last", empty, 1'b1);
    burst(1'b0, 513);
    check("full flags", {full, near_full_warning, overflow_error}, 3'h7);
    check("write count wrap", write_pointer_value, 9'h3);
    rd_reg(`DCF_STATUS_OFS, (32'h1 << `DCF_ST_FULL_BIT) | (32'h1 << `DCF_ST_NFULL_BIT) | (32'h1 << `DCF_ST_OVER_BIT));
    repeat (10) @(posedge clk);
    check("overflow clear", overflow_error, 1'b0);
    repeat (2) rd_chk("full data");
    repeat (60) @(posedge clk);
    check("full release", full, 1'b0);
    while (q.size() > 0) begin
      rd_chk("drain data");
      if (q.size() == 20) check("near empty off", near_empty_warning, 1'b0);
      if (q.size() == 10) check("near empty on", near_empty_warning, 1'b1);
    end
    check("empty at end", empty, 1'b1);
    burst(1'b1, 1);
    check("underflow", {underflow_error, read_pointer_value}, {1'b1, 9'h3});
    repeat (12) @(posedge clk);
    check("underflow clear", underflow_error, 1'b0);
    last = {read_parity_out, read_data_out};
    fifo_rst(32'h1 << `DCF_CFG_AHEAD_BIT);
    check("output kept", {read_parity_out, read_data_out}, last);
    check("pointers cleared", {read_pointer_value, write_pointer_value}, 18'h0);
    burst(1'b0, 2);
    repeat (80) @(posedge clk);
    check("fall through", {read_parity_out, read_data_out}, q.pop_front());
    rd_chk("ahead data");
    fifo_rst(32'h1 << `DCF_CFG_SINGLE_BIT);
    burst(1'b0, 1);
    check("single empty", empty, 1'b0);
    rd_chk("single data");
    // The piped form shows a read one write tick later than the plain form.
    fifo_rst(32'h1 << `DCF_CFG_SINGLE_BIT | 32'h1 << `DCF_CFG_PIPE_BIT);
    burst(1'b0, 1);
    last = {read_parity_out, read_data_out};
    burst(1'b1, 1);
    check("piped lag", {read_parity_out, read_data_out}, last);
    repeat (8) @(posedge clk);
    check("piped data", {read_parity_out, read_data_out}, q.pop_front());
    oreg_rst <= 1'b1;
    repeat (30) @(posedge clk);
    check("output reset", {read_parity_out, read_data_out}, 36'h0);
    finish_test();
  end
  // A hang is cut short well beyond the expected run of about 15000 cycles.
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    finish_test();
  end
endmodule
bind dcf_fifo dcf_fifo_assertions #(.ADDR_W(ADDR_W)) u_dcf_fifo_assertions (.clk, .reset_n, .fifo_reset,
  .empty, .near_empty_warning, .full, .near_full_warning, .underflow_error, .overflow_error,
  .read_pointer_value, .write_pointer_value);
